/* File: ucf_pkg.sv */
// Constants, register map and state types of the UART framing and flow control block.
package ucf_pkg;

	// ---------------------------------------------------------------
	// Clock and register map
	// ---------------------------------------------------------------
	localparam int         CLK_HZ          = 20_000_000;
	// Register indices; the byte address on the bus is four times the index.
	localparam logic [5:0] IDX_UART_ON     = 6'h01;
	localparam logic [5:0] IDX_DIVISOR     = 6'h04;
	localparam logic [5:0] IDX_SEND_PAT    = 6'h07;
	localparam logic [5:0] IDX_RECV_PAT    = 6'h09;
	localparam logic [5:0] IDX_FRAME_SHAPE = 6'h0b;
	localparam logic [5:0] IDX_HANDSHAKE   = 6'h0c;
	localparam logic [5:0] IDX_RESUME      = 6'h10;
	localparam logic [5:0] IDX_PAUSE       = 6'h11;
	localparam logic [5:0] IDX_PIN_MODE    = 6'h1a;
	localparam logic [5:0] IDX_STATUS      = 6'h20;
	localparam logic [5:0] IDX_TX_DATA     = 6'h21;
	localparam logic [5:0] IDX_RX_DATA     = 6'h22;
	localparam logic [5:0] IDX_NODE_ADDR   = 6'h23;

	// ---------------------------------------------------------------
	// Field positions, codes and reset values
	// ---------------------------------------------------------------
	localparam int         FS_STOP_BIT     = 7;
	localparam int         HM_HALF_DUPLEX  = 3;
	localparam int         ST_ERR_LSB      = 5;
	localparam logic [3:0] WL_7            = 4'h7;
	localparam logic [3:0] WL_8            = 4'h8;
	localparam logic [3:0] WL_9            = 4'h9;
	localparam logic [2:0] PAR_NONE        = 3'h0;
	localparam logic [2:0] PAR_ODD         = 3'h1;
	localparam logic [2:0] PAR_EVEN        = 3'h2;
	localparam logic [2:0] PAR_MARK        = 3'h3;
	localparam logic [2:0] PAR_SPACE       = 3'h4;
	localparam logic [2:0] HM_NONE         = 3'h0;
	localparam logic [2:0] HM_HW           = 3'h1;
	localparam logic [2:0] HM_SW           = 3'h2;
	localparam logic [2:0] HM_ADDR_RX      = 3'h3;
	localparam logic [2:0] HM_ADDR_RXTX    = 3'h4;
	localparam logic [2:0] PM_RTS_CTS      = 3'h1;
	localparam logic [2:0] PM_DTR_DSR      = 3'h2;
	localparam logic [18:0] RST_DIVISOR    = 19'h000ae;
	localparam logic [7:0] RST_FRAME_SHAPE = 8'h08;

	typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} ucf_tx_e;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} ucf_rx_e;

endpackage

/* File: ucf_top.sv */
// UART channel with character framing, fractional baud timing and flow control.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module ucf_top
	import ucf_pkg::*;
#(
	parameter int QDEPTH = 2
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial line
	input  wire logic        rxd,
	output logic             txd,
	// General pins (three-signal form)
	input  wire logic [5:0]  general_pin_in,
	output logic      [5:0]  general_pin_out,
	output logic      [5:0]  general_pin_oe
);

	localparam int QAW = $clog2(QDEPTH);

	// ---------------------------------------------------------------
	// Helper functions
	// ---------------------------------------------------------------
	// word length decode
	function automatic logic [3:0] word_len(input logic [3:0] code);
		// Reserved codes fall back to eight bits.
		word_len = (code == WL_7 || code == WL_9) ? code : WL_8;
	endfunction

	// one bit period, stretched by the fraction pattern
	function automatic logic [19:0] bit_time(input logic [18:0] dv, input logic [15:0] pat,
	                                         input logic [3:0] idx);
		bit_time = {1'b0, dv} + {19'h00000, pat[idx]};
	endfunction

	// parity value for the given word
	function automatic logic par_val(input logic [8:0] d, input logic [2:0] mode);
		unique case (mode)
			PAR_ODD:   par_val = ~(^d);
			PAR_EVEN:  par_val = ^d;
			PAR_MARK:  par_val = 1'b1;
			default:   par_val = 1'b0;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [1:0]  on_reg, on_next;
	logic [18:0] div_reg, div_next;
	logic [15:0] spat_reg, spat_next, rpat_reg, rpat_next;
	logic [7:0]  frame_shape_reg, frame_shape_next, handshake_mode_reg, handshake_mode_next;
	logic [7:0]  resume_char_reg, resume_char_next, pause_char_reg, pause_char_next;
	logic [7:0]  node_reg, node_next;
	logic [2:0]  pin_mode_reg, pin_mode_next, err_reg, err_next;
	logic        paused_reg, paused_next, matched_reg, matched_next;
	logic        pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;
	logic [5:0]  gp_out_reg, gp_out_next, gp_oe_reg, gp_oe_next;
	logic [8:0]  tq_mem [QDEPTH], rq_mem [QDEPTH];
	logic [QAW-1:0] tq_wp_reg, tq_wp_next, tq_rp_reg, tq_rp_next;
	logic [QAW-1:0] rq_wp_reg, rq_wp_next, rq_rp_reg, rq_rp_next;
	logic [QAW:0]   tq_cnt_reg, tq_cnt_next, rq_cnt_reg, rq_cnt_next;
	logic        tq_push, rq_pop;
	logic [1:0]  rxd_sync_reg, gp2_sync_reg, gp4_sync_reg;
	logic [3:0]  nd;
	logic        pe, two_stop, half_dup, cts_off, tx_busy;
	logic [3:0]  nbits;
	logic [5:0]  idx;
	logic        acc;
	// Transmit engine
	ucf_tx_e     tx_st_reg, tx_st_next;
	logic [11:0] tx_sh_reg, tx_sh_next;
	logic [3:0]  tx_bits_reg, tx_bits_next, tx_bi_reg, tx_bi_next;
	logic [19:0] tx_cnt_reg, tx_cnt_next;
	logic        txd_reg, txd_next, tq_pop;
	// Receive engine
	ucf_rx_e     rx_st_reg, rx_st_next;
	logic [11:0] rx_sh_reg, rx_sh_next, rx_full;
	logic [3:0]  rx_bits_reg, rx_bits_next, rx_bi_reg, rx_bi_next;
	logic [19:0] rx_cnt_reg, rx_cnt_next;
	logic        rq_push, err_frm, err_par, err_ovr, pause_hit, resume_hit;
	logic        match_hit, match_miss;
	logic [8:0]  rx_word;

	// ---------------------------------------------------------------
	// Input synchronisers and framing decode
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rxd_sync_reg <= 2'h3;
			gp2_sync_reg <= 2'h3;
			gp4_sync_reg <= 2'h3;
		end else begin
			rxd_sync_reg <= {rxd_sync_reg[0], rxd};
			gp2_sync_reg <= {gp2_sync_reg[0], general_pin_in[2]};
			gp4_sync_reg <= {gp4_sync_reg[0], general_pin_in[4]};
		end
	end

	always_comb begin
		nd       = word_len(frame_shape_reg[3:0]);
		// no parity bit with nine-bit words
		pe       = (nd != WL_9) && (frame_shape_reg[6:4] != PAR_NONE);
		two_stop = frame_shape_reg[FS_STOP_BIT];
		nbits    = nd + {3'h0, pe} + {3'h0, two_stop} + 4'h1;
		half_dup = handshake_mode_reg[HM_HALF_DUPLEX];
		tx_busy  = (tx_st_reg == TX_SHIFT);
		// clear-to-send or set-ready input, active low
		cts_off  = (pin_mode_reg == PM_RTS_CTS) ? gp4_sync_reg[1] :
		           (pin_mode_reg == PM_DTR_DSR) ? gp2_sync_reg[1] : 1'b0;
	end

	// ---------------------------------------------------------------
	// Register file, bus slave, buffers and flow state
	// ---------------------------------------------------------------
	always_comb begin
		on_next             = on_reg;
		div_next            = div_reg;
		spat_next           = spat_reg;
		rpat_next           = rpat_reg;
		frame_shape_next    = frame_shape_reg;
		handshake_mode_next = handshake_mode_reg;
		resume_char_next    = resume_char_reg;
		pause_char_next     = pause_char_reg;
		node_next           = node_reg;
		pin_mode_next       = pin_mode_reg;
		err_next            = err_reg;
		paused_next         = paused_reg;
		matched_next        = matched_reg;
		prdata_next         = prdata_reg;
		pslverr_next        = 1'b0;
		tq_push             = 1'b0;
		rq_pop              = 1'b0;
		idx                 = paddr[7:2];
		acc                 = psel && penable && pready_reg;
		// A write to a full transmit buffer holds pready low until a word leaves.
		pready_next = psel && penable && !pready_reg &&
		              !(pwrite && idx == IDX_TX_DATA && tq_cnt_reg == QDEPTH[QAW:0]);
		if (pready_next) begin
			prdata_next = 32'h00000000;
			unique case (idx)
				IDX_UART_ON:     prdata_next[1:0]  = on_reg;
				IDX_DIVISOR:     prdata_next[18:0] = div_reg;
				IDX_SEND_PAT:    prdata_next[15:0] = spat_reg;
				IDX_RECV_PAT:    prdata_next[15:0] = rpat_reg;
				IDX_FRAME_SHAPE: prdata_next[7:0]  = frame_shape_reg;
				IDX_HANDSHAKE:   prdata_next[7:0]  = handshake_mode_reg;
				IDX_RESUME:      prdata_next[7:0]  = resume_char_reg;
				IDX_PAUSE:       prdata_next[7:0]  = pause_char_reg;
				IDX_PIN_MODE:    prdata_next[2:0]  = pin_mode_reg;
				IDX_NODE_ADDR:   prdata_next[7:0]  = node_reg;
				IDX_STATUS:      prdata_next[7:0]  = {err_reg, matched_reg, paused_reg,
				                                      rq_cnt_reg != '0,
				                                      tq_cnt_reg == QDEPTH[QAW:0], tx_busy};
				IDX_RX_DATA:     prdata_next[8:0]  = (rq_cnt_reg != '0) ? rq_mem[rq_rp_reg]
				                                                       : 9'h000;
				IDX_TX_DATA:     prdata_next       = 32'h00000000;
				default:         pslverr_next      = 1'b1;
			endcase
		end
		if (acc && pwrite) begin
			unique case (idx)
				IDX_UART_ON:     on_next          = pwdata[1:0];
				IDX_DIVISOR:     div_next         = pwdata[18:0];
				IDX_SEND_PAT:    spat_next        = pwdata[15:0];
				IDX_RECV_PAT:    rpat_next        = pwdata[15:0];
				IDX_FRAME_SHAPE: begin
					frame_shape_next = pwdata[7:0];
					// parity field held while nine-bit words are in force
					if (frame_shape_reg[3:0] == WL_9) begin
						frame_shape_next[6:4] = frame_shape_reg[6:4];
					end
				end
				// handshake mode changes are taken only while the channel is off
				IDX_HANDSHAKE:   if (on_reg == 2'h0) handshake_mode_next = {4'h0, pwdata[3:0]};
				IDX_RESUME:      resume_char_next = pwdata[7:0];
				IDX_PAUSE:       pause_char_next  = pwdata[7:0];
				IDX_PIN_MODE:    pin_mode_next    = pwdata[2:0];
				IDX_NODE_ADDR:   node_next        = pwdata[7:0];
				IDX_STATUS:      err_next         = err_reg & ~pwdata[7:ST_ERR_LSB];
				IDX_TX_DATA:     tq_push          = 1'b1;
				default:         ;
			endcase
		end
		if (acc && !pwrite && idx == IDX_RX_DATA && rq_cnt_reg != '0) begin
			rq_pop = 1'b1;
		end
		// Error events win over a clear in the same cycle.
		err_next = err_next | {err_ovr, err_par, err_frm};
		if (resume_hit) begin
			paused_next = 1'b0;
		end
		if (pause_hit) begin
			paused_next = 1'b1;
		end
		if (match_hit) begin
			matched_next = 1'b1;
		end else if (match_miss) begin
			matched_next = 1'b0;
		end
		tq_wp_next  = tq_push ? tq_wp_reg + 1'b1 : tq_wp_reg;
		tq_rp_next  = tq_pop  ? tq_rp_reg + 1'b1 : tq_rp_reg;
		tq_cnt_next = tq_cnt_reg + {{QAW{1'b0}}, tq_push} - {{QAW{1'b0}}, tq_pop};
		rq_wp_next  = rq_push ? rq_wp_reg + 1'b1 : rq_wp_reg;
		rq_rp_next  = rq_pop  ? rq_rp_reg + 1'b1 : rq_rp_reg;
		rq_cnt_next = rq_cnt_reg + {{QAW{1'b0}}, rq_push} - {{QAW{1'b0}}, rq_pop};
		// request output tells the far end to stop while receive space is gone
		gp_out_next = 6'h00;
		gp_oe_next  = 6'h00;
		if (handshake_mode_reg[2:0] == HM_HW) begin
			// route the request output by pin mode
			if (pin_mode_reg == PM_RTS_CTS) begin
				gp_oe_next[5]  = 1'b1;
				gp_out_next[5] = (rq_cnt_reg == QDEPTH[QAW:0]);
			end else if (pin_mode_reg == PM_DTR_DSR) begin
				gp_oe_next[3]  = 1'b1;
				gp_out_next[3] = (rq_cnt_reg == QDEPTH[QAW:0]);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			on_reg             <= 2'h0;
			div_reg            <= RST_DIVISOR;
			spat_reg           <= 16'h0000;
			rpat_reg           <= 16'h0000;
			frame_shape_reg    <= RST_FRAME_SHAPE;
			handshake_mode_reg <= 8'h00;
			resume_char_reg    <= 8'h00;
			pause_char_reg     <= 8'h00;
			node_reg           <= 8'h00;
			pin_mode_reg       <= 3'h0;
			err_reg            <= 3'h0;
			paused_reg         <= 1'b0;
			matched_reg        <= 1'b0;
			pready_reg         <= 1'b0;
			pslverr_reg        <= 1'b0;
			prdata_reg         <= 32'h00000000;
			gp_out_reg         <= 6'h00;
			gp_oe_reg          <= 6'h00;
			tq_wp_reg          <= '0;
			tq_rp_reg          <= '0;
			tq_cnt_reg         <= '0;
			rq_wp_reg          <= '0;
			rq_rp_reg          <= '0;
			rq_cnt_reg         <= '0;
		end else begin
			on_reg             <= on_next;
			div_reg            <= div_next;
			spat_reg           <= spat_next;
			rpat_reg           <= rpat_next;
			frame_shape_reg    <= frame_shape_next;
			handshake_mode_reg <= handshake_mode_next;
			resume_char_reg    <= resume_char_next;
			pause_char_reg     <= pause_char_next;
			node_reg           <= node_next;
			pin_mode_reg       <= pin_mode_next;
			err_reg            <= err_next;
			paused_reg         <= paused_next;
			matched_reg        <= matched_next;
			pready_reg         <= pready_next;
			pslverr_reg        <= pslverr_next;
			prdata_reg         <= prdata_next;
			gp_out_reg         <= gp_out_next;
			gp_oe_reg          <= gp_oe_next;
			tq_wp_reg          <= tq_wp_next;
			tq_rp_reg          <= tq_rp_next;
			tq_cnt_reg         <= tq_cnt_next;
			rq_wp_reg          <= rq_wp_next;
			rq_rp_reg          <= rq_rp_next;
			rq_cnt_reg         <= rq_cnt_next;
		end
	end

	// Buffer storage needs no reset; the counts guard every read.
	always_ff @(posedge clk_sys) begin
		if (tq_push) begin
			tq_mem[tq_wp_reg] <= pwdata[8:0];
		end
		if (rq_push) begin
			rq_mem[rq_wp_reg] <= rx_word;
		end
	end

	// ---------------------------------------------------------------
	// Transmit engine
	// ---------------------------------------------------------------
	always_comb begin
		logic [8:0] d;
		d            = 9'h000;
		tx_st_next   = tx_st_reg;
		tx_sh_next   = tx_sh_reg;
		tx_bits_next = tx_bits_reg;
		tx_bi_next   = tx_bi_reg;
		tx_cnt_next  = tx_cnt_reg;
		txd_next     = txd_reg;
		tq_pop       = 1'b0;
		unique case (tx_st_reg)
			TX_IDLE: begin
				txd_next = 1'b1;
				if (on_reg[0] && tq_cnt_reg != '0 &&
				    !(handshake_mode_reg[2:0] == HM_SW && paused_reg) &&
				    !(handshake_mode_reg[2:0] == HM_HW && cts_off) &&
				    !(handshake_mode_reg[2:0] == HM_ADDR_RXTX && !matched_reg)) begin
					tq_pop = 1'b1;
					d      = tq_mem[tq_rp_reg];
					if (nd == WL_7) d[8:7] = 2'h0;
					if (nd == WL_8) d[8]   = 1'b0;
					// Stop bits are the ones above the word and parity.
					tx_sh_next = {3'h7, d};
					if (nd == WL_7) tx_sh_next[8:7] = 2'h3;
					if (nd == WL_8) tx_sh_next[8]   = 1'b1;
					// parity bit placed right after the data
					if (pe) tx_sh_next[nd] = par_val(d, frame_shape_reg[6:4]);
					tx_bits_next = nbits;
					tx_bi_next   = 4'h0;
					tx_cnt_next  = bit_time(div_reg, spat_reg, 4'h0);
					txd_next     = 1'b0;
					tx_st_next   = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				if (tx_cnt_reg > 20'h00001) begin
					tx_cnt_next = tx_cnt_reg - 20'h00001;
				end else if (tx_bits_reg == 4'h0) begin
					txd_next   = 1'b1;
					tx_st_next = TX_IDLE;
				end else begin
					txd_next     = tx_sh_reg[0];
					tx_sh_next   = {1'b1, tx_sh_reg[11:1]};
					tx_bits_next = tx_bits_reg - 4'h1;
					tx_bi_next   = tx_bi_reg + 4'h1;
					tx_cnt_next  = bit_time(div_reg, spat_reg, tx_bi_reg + 4'h1);
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_reg   <= TX_IDLE;
			tx_sh_reg   <= 12'hfff;
			tx_bits_reg <= 4'h0;
			tx_bi_reg   <= 4'h0;
			tx_cnt_reg  <= 20'h00000;
			txd_reg     <= 1'b1;
		end else begin
			tx_st_reg   <= tx_st_next;
			tx_sh_reg   <= tx_sh_next;
			tx_bits_reg <= tx_bits_next;
			tx_bi_reg   <= tx_bi_next;
			tx_cnt_reg  <= tx_cnt_next;
			txd_reg     <= txd_next;
		end
	end

	// ---------------------------------------------------------------
	// Receive engine
	// ---------------------------------------------------------------
	always_comb begin
		logic done;
		logic store;
		done         = 1'b0;
		store        = 1'b0;
		rx_st_next   = rx_st_reg;
		rx_sh_next   = rx_sh_reg;
		rx_bits_next = rx_bits_reg;
		rx_bi_next   = rx_bi_reg;
		rx_cnt_next  = rx_cnt_reg;
		rq_push      = 1'b0;
		err_frm      = 1'b0;
		err_par      = 1'b0;
		err_ovr      = 1'b0;
		pause_hit    = 1'b0;
		resume_hit   = 1'b0;
		match_hit    = 1'b0;
		match_miss   = 1'b0;
		rx_full      = {rxd_sync_reg[1], rx_sh_reg[11:1]} >> (4'd12 - nbits);
		rx_word      = rx_full[8:0];
		if (nd == WL_7) rx_word[8:7] = 2'h0;
		if (nd == WL_8) rx_word[8]   = 1'b0;
		unique case (rx_st_reg)
			RX_IDLE: begin
				// line ignored while sending in half-duplex
				if (on_reg[1] && !rxd_sync_reg[1] && !(half_dup && tx_busy)) begin
					rx_cnt_next = {1'b0, div_reg >> 1};
					rx_st_next  = RX_START;
				end
			end
			RX_START: begin
				if (rx_cnt_reg > 20'h00001) begin
					rx_cnt_next = rx_cnt_reg - 20'h00001;
				end else if (rxd_sync_reg[1]) begin
					rx_st_next = RX_IDLE;
				end else begin
					rx_bits_next = nbits;
					rx_bi_next   = 4'h0;
					rx_cnt_next  = bit_time(div_reg, rpat_reg, 4'h0);
					rx_st_next   = RX_DATA;
				end
			end
			RX_DATA: begin
				if (half_dup && tx_busy) begin
					// a character cut by our own transmission is dropped
					rx_st_next = RX_IDLE;
				end else if (rx_cnt_reg > 20'h00001) begin
					rx_cnt_next = rx_cnt_reg - 20'h00001;
				end else begin
					rx_sh_next   = {rxd_sync_reg[1], rx_sh_reg[11:1]};
					rx_bits_next = rx_bits_reg - 4'h1;
					rx_bi_next   = rx_bi_reg + 4'h1;
					rx_cnt_next  = bit_time(div_reg, rpat_reg, rx_bi_reg + 4'h1);
					if (rx_bits_reg == 4'h1) begin
						done       = 1'b1;
						rx_st_next = RX_IDLE;
					end
				end
			end
			default: rx_st_next = RX_IDLE;
		endcase
		if (done) begin
			// every expected stop bit is checked
			err_frm = !rx_full[nd + {3'h0, pe}] ||
			          (two_stop && !rx_full[nd + {3'h0, pe} + 4'h1]);
			err_par = pe && (rx_full[nd] != par_val(rx_word, frame_shape_reg[6:4]));
			store   = 1'b1;
			unique case (handshake_mode_reg[2:0])
				HM_SW: begin
					if (rx_word[7:0] == pause_char_reg) begin
						pause_hit = 1'b1;
						store     = 1'b0;
					end else if (rx_word[7:0] == resume_char_reg) begin
						resume_hit = 1'b1;
						store      = 1'b0;
					end
				end
				HM_ADDR_RX, HM_ADDR_RXTX: begin
					// ninth bit marks an address character
					if (nd == WL_9 && rx_word[8]) begin
						match_hit  = (rx_word[7:0] == node_reg);
						match_miss = !match_hit;
						store      = 1'b0;
					end else begin
						store = matched_reg;
					end
				end
				default: store = 1'b1;
			endcase
			if (store) begin
				rq_push = (rq_cnt_reg != QDEPTH[QAW:0]) || rq_pop;
				err_ovr = !rq_push;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_reg   <= RX_IDLE;
			rx_sh_reg   <= 12'h000;
			rx_bits_reg <= 4'h0;
			rx_bi_reg   <= 4'h0;
			rx_cnt_reg  <= 20'h00000;
		end else begin
			rx_st_reg   <= rx_st_next;
			rx_sh_reg   <= rx_sh_next;
			rx_bits_reg <= rx_bits_next;
			rx_bi_reg   <= rx_bi_next;
			rx_cnt_reg  <= rx_cnt_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign prdata          = prdata_reg;
	assign pready          = pready_reg;
	assign pslverr         = pslverr_reg;
	assign txd             = txd_reg;
	assign general_pin_out = gp_out_reg;
	assign general_pin_oe  = gp_oe_reg;

endmodule

`default_nettype wire

/* File: ucf_sva.sv */
// Port checker for the framing and flow control block.
`timescale 1ns/10ps
`default_nettype none
module ucf_sva
	import ucf_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        txd,
	input wire logic [5:0]  general_pin_out,
	input wire logic [5:0]  general_pin_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
	a_ready_time: assert property (psel && penable && !pready && paddr[7:2] != IDX_TX_DATA
		|=> pready) else $error("ready late");
	a_ready_req: assert property (pready |-> psel && penable) else $error("ready unasked");
	a_err_data: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
	a_start_width: assert property ($fell(txd) |=> !txd [*3]) else $error("start short");
	a_unused_oe: assert property ((general_pin_oe & 6'h17) == 6'h00) else $error("stray oe");
	a_out_oe: assert property ((general_pin_out & ~general_pin_oe) == 6'h00)
		else $error("undriven out");
	a_oe_pair: assert property (!(general_pin_oe[3] && general_pin_oe[5]))
		else $error("both pins");
	cover property (pslverr);
	cover property ($fell(txd));
	cover property (general_pin_out[5]);
endmodule
bind ucf_top ucf_sva ucf_sva_inst (.clk_sys, .rst_n, .psel, .penable, .paddr, .prdata,
	.pready, .pslverr, .txd, .general_pin_out, .general_pin_oe);
`default_nettype wire

/* File: ucf_partner.sv */
// Remote serial device: drives the receive line and samples the send line.
`timescale 1ns/10ps
`default_nettype none
module ucf_partner #(
	parameter int BIT = 8
) (
	input  wire logic clk_sys,
	input  wire logic txd,
	output var logic  rxd
);
	initial rxd = 1'b1;
	// start, data low bit first, one stop
	task send(input logic [8:0] d, input int n);
		for (int k = -1; k <= n; k++) begin
			rxd <= (k < 0) ? 1'b0 : (k == n) ? 1'b1 : d[k];
			repeat (BIT) @(posedge clk_sys);
		end
	endtask
	// Samples each bit in its middle, so a late next start still reads low.
	task grab(output logic [15:0] v);
		@(negedge txd);
		repeat (BIT / 2) @(posedge clk_sys);
		for (int k = 0; k < 16; k++) begin
			v[k] = txd;
			repeat (BIT) @(posedge clk_sys);
		end
	endtask
endmodule
`default_nettype wire

/* File: ucf_top_bench.sv */
// Self-checking bench for the framing and flow control block.
`timescale 1ns/10ps
`default_nettype none
module ucf_top_bench;
	import ucf_pkg::*;
	logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, rxd, txd, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0]  general_pin_in, general_pin_out, general_pin_oe;
	logic [15:0] fr;
	logic [15:0] tbl [8];
	int          err_total, compares, i;
	ucf_top ucf_top_inst (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rxd, .txd, .general_pin_in, .general_pin_out, .general_pin_oe);
	ucf_partner ucf_partner_inst (.clk_sys, .txd, .rxd);
	task apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
		@(posedge clk_sys);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, idx, 2'b00, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		{rd, er} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Expected line: two back-to-back frames of the same word.
	function automatic logic [15:0] fexp(input logic [7:0] fs);
		logic [31:0] v;
		logic [8:0]  d;
		logic        x;
		int          n, k;
		d = 9'h1a5;
		n = (fs[3:0] == WL_7) ? 7 : (fs[3:0] == WL_9) ? 9 : 8;
		x = ^(d & ((9'h1 << n) - 9'h1));
		v = '1;
		k = 0;
		for (int j = 0; j < 2; j++) begin
			v[k] = 1'b0;
			for (int m = 0; m < n; m++) v[k + 1 + m] = d[m];
			k = k + 1 + n;
			if (n < 9 && fs[6:4] != PAR_NONE) begin
				v[k] = (fs[6:4] == PAR_ODD) ? ~x : (fs[6:4] == PAR_EVEN) ? x : fs[6:4] == PAR_MARK;
				k++;
			end
			k = k + 1 + fs[FS_STOP_BIT];
		end
		return v[15:0];
	endfunction
	task stop_test;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task frame(input logic [7:0] fs);
		fork
			ucf_partner_inst.grab(fr);
			begin
				apb(1, IDX_TX_DATA, 32'h1a5);
				apb(1, IDX_TX_DATA, 32'h1a5);
			end
		join
		chk(fr, fexp(fs));
		repeat (160) @(posedge clk_sys);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		err_total++;
		stop_test;
	end
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, general_pin_in} = '0;
		tbl = '{16'h0808, 16'h1818, 16'h2828, 16'h3838, 16'h4848, 16'h8787, 16'h8989, 16'h1909};
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		apb(0, IDX_FRAME_SHAPE, 32'h0);
		chk(rd, {24'h0, RST_FRAME_SHAPE});
		apb(0, 6'h3f, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1, IDX_DIVISOR, 32'h8);
		apb(1, IDX_SEND_PAT, 32'h0);
		apb(1, IDX_RECV_PAT, 32'h0);
		apb(1, IDX_UART_ON, 32'h1);
		for (i = 0; i < 8; i++) begin
			apb(1, IDX_FRAME_SHAPE, {24'h0, tbl[i][15:8]});
			apb(0, IDX_FRAME_SHAPE, 32'h0);
			chk(rd, {24'h0, tbl[i][7:0]});
			frame(tbl[i][7:0]);
		end
		chk({26'h0, general_pin_oe}, 32'h0);
		$display("test framing done");
		apb(1, IDX_UART_ON, 32'h0);
		apb(1, IDX_FRAME_SHAPE, 32'h8);
		apb(1, IDX_HANDSHAKE, {29'h0, HM_SW});
		apb(1, IDX_RESUME, 32'h11);
		apb(1, IDX_PAUSE, 32'h13);
		apb(1, IDX_UART_ON, 32'h3);
		ucf_partner_inst.send(9'h13, 8);
		apb(1, IDX_TX_DATA, 32'h1a5);
		apb(1, IDX_TX_DATA, 32'h1a5);
		repeat (200) @(posedge clk_sys);
		apb(0, IDX_STATUS, 32'h0);
		chk({24'h0, rd[7:0]}, 32'h0a);
		fork
			ucf_partner_inst.send(9'h11, 8);
			ucf_partner_inst.grab(fr);
		join
		chk(fr, fexp(8'h08));
		ucf_partner_inst.send(9'h41, 8);
		apb(0, IDX_RX_DATA, 32'h0);
		chk(rd, 32'h41);
		repeat (160) @(posedge clk_sys);
		$display("test pause resume done");
		apb(1, IDX_UART_ON, 32'h0);
		apb(1, IDX_HANDSHAKE, {29'h0, HM_HW});
		apb(1, IDX_PIN_MODE, {29'h0, PM_DTR_DSR});
		repeat (2) @(posedge clk_sys);
		chk({20'h0, general_pin_oe, general_pin_out}, 32'h200);
		apb(1, IDX_PIN_MODE, {29'h0, PM_RTS_CTS});
		general_pin_in[4] <= 1'b1;
		apb(1, IDX_UART_ON, 32'h3);
		apb(1, IDX_TX_DATA, 32'h1a5);
		apb(1, IDX_TX_DATA, 32'h1a5);
		ucf_partner_inst.send(9'h61, 8);
		ucf_partner_inst.send(9'h62, 8);
		repeat (2) @(posedge clk_sys);
		chk({20'h0, general_pin_oe, general_pin_out}, 32'h820);
		fork
			general_pin_in[4] <= 1'b0;
			ucf_partner_inst.grab(fr);
		join
		chk(fr, fexp(8'h08));
		apb(0, IDX_RX_DATA, 32'h0);
		chk(rd, 32'h61);
		repeat (3) @(posedge clk_sys);
		chk({26'h0, general_pin_out}, 32'h0);
		$display("test hardware flow done");
		apb(0, IDX_RX_DATA, 32'h0);
		chk(rd, 32'h62);
		apb(1, IDX_UART_ON, 32'h0);
		apb(1, IDX_FRAME_SHAPE, 32'h9);
		apb(1, IDX_HANDSHAKE, {29'h0, HM_ADDR_RX});
		apb(1, IDX_NODE_ADDR, 32'h5a);
		apb(1, IDX_UART_ON, 32'h3);
		ucf_partner_inst.send(9'h077, 9);
		ucf_partner_inst.send(9'h15a, 9);
		ucf_partner_inst.send(9'h0c3, 9);
		apb(0, IDX_RX_DATA, 32'h0);
		chk(rd, 32'hc3);
		apb(0, IDX_STATUS, 32'h0);
		chk({24'h0, rd[7:0]}, 32'h10);
		$display("test multidrop done");
		stop_test;
	end
endmodule
`default_nettype wire
